// *** rtl/scms_mode_selector.sv ***
// Control mode selector: picks the active mode and command sources.
// Assumes switch and select pins are asynchronous to i_core_clk and
// that the mode and limit parameters are static core-domain levels.
`timescale 1ns/10ps
module scms_mode_selector
  import scms_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  input  wire logic [7:0] i_control_mode_parameter,
  input  wire logic [1:0] i_limit_enable_parameter,
  input  wire logic       i_single_torque_mode,
  input  wire logic       i_zero_torque_variant,
  input  wire logic       i_servo_on,
  input  wire logic       i_speed_pos_switch,
  input  wire logic       i_speed_torque_switch,
  input  wire logic       i_torque_pos_switch,
  input  wire logic       i_pos_table_switch,
  input  wire logic       i_position_trigger,
  input  wire logic [1:0] i_speed_select_inputs,
  input  wire logic [1:0] i_torque_select_inputs,
  input  wire logic [5:0] i_position_select_inputs,
  output scms_mode_t      o_active_mode,
  output logic            o_code_valid,
  output logic            o_motor_hold,
  output logic            o_pos_from_pulses,
  output logic            o_pos_move,
  output logic [5:0]      o_position_preset,
  output logic [1:0]      o_speed_source,
  output logic [1:0]      o_torque_source,
  output logic            o_torque_zero,
  output logic            o_speed_limit_on,
  output logic [1:0]      o_speed_limit_source,
  output logic            o_torque_limit_on,
  output logic [1:0]      o_torque_limit_source
);

`include "scms_defines.svh"

  // ============================================================
  // Decoding helpers.

  // True for every dual or multiple mode code this block serves.
  function automatic logic is_dual(input logic [7:0] code);
    case (code)
      `SCMS_CODE_PT_S, `SCMS_CODE_PT_T, `SCMS_CODE_PR_S,
      `SCMS_CODE_PR_T, `SCMS_CODE_S_T, `SCMS_CODE_PT_PR,
      `SCMS_CODE_PT_PR_S, `SCMS_CODE_PT_PR_T: is_dual = 1'b1;
      default: is_dual = 1'b0;
    endcase
  endfunction

  // Position flavour picked by the table switch in multiple modes.
  function automatic scms_mode_t pos_pick(input logic table_sel);
    pos_pick = table_sel ? SCMS_MODE_PR : SCMS_MODE_PT;
  endfunction

  // ============================================================
  // Input synchronisation.
  logic [`SCMS_SYNC_W-1:0] raw;  // Pin bundle before crossing.
  logic [`SCMS_SYNC_W-1:0] st;   // Filtered core-domain copy.

  assign raw = {1'b0, i_position_select_inputs, i_torque_select_inputs,
                i_speed_select_inputs, i_servo_on, i_position_trigger,
                i_pos_table_switch, i_torque_pos_switch,
                i_speed_torque_switch, i_speed_pos_switch};

  // Every mode, select and trigger pin crosses here.
  scms_sync #(.W (`SCMS_SYNC_W)) u_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_async    (raw),
    .o_stable   (st)
  );

  logic       sp_sw;     // Speed/position switch, active high.
  logic       stq_sw;    // Speed/torque switch, active high.
  logic       tp_sw;     // Torque/position switch, active high.
  logic       tbl_sw;    // Pulse-train or table position choice.
  logic       trig;      // Synchronised position trigger.
  logic       srv_on;    // Synchronised servo-on level.
  logic [1:0] spd_sel;   // Speed select inputs.
  logic [1:0] tcm_sel;   // Torque select inputs.
  logic [5:0] pos_sel;   // Position select inputs.
  logic       trig_d;    // Trigger one sample earlier.
  logic       trig_rise; // Single-cycle rising edge of the trigger.

  assign sp_sw   = st[`SCMS_SY_SP];
  assign stq_sw  = st[`SCMS_SY_ST];
  assign tp_sw   = st[`SCMS_SY_TP];
  assign tbl_sw  = st[`SCMS_SY_PP];
  assign trig    = st[`SCMS_SY_TRIG];
  assign srv_on  = st[`SCMS_SY_SRVON];
  assign spd_sel = st[`SCMS_SY_SPD +: 2];
  assign tcm_sel = st[`SCMS_SY_TCM +: 2];
  assign pos_sel = st[`SCMS_SY_POS +: 6];

  // Edge detector works on filtered samples only, never stage one.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trig_d <= 1'b0;
    end else begin
      trig_d <= trig;
    end
  end

  assign trig_rise = trig & ~trig_d;

  // ============================================================
  // Mode decode.
  scms_mode_t next_mode;  // Mode the switches ask for now.
  logic       dual;       // Code is one of the served codes.
  logic       tz_ok;      // Zero-torque variant is honoured.

  assign dual = is_dual(i_control_mode_parameter);
  // Zero variants never combine with a dual code.
  assign tz_ok = i_zero_torque_variant & ~dual & i_single_torque_mode;

  // Switch levels map straight onto a mode, so every return to speed
  // or torque takes effect on the next edge.
  always_comb begin
    next_mode = SCMS_MODE_NONE;
    case (i_control_mode_parameter)
      `SCMS_CODE_PT_S: begin
        next_mode = sp_sw ? SCMS_MODE_SPEED : SCMS_MODE_PT;
      end
      `SCMS_CODE_PR_S: begin
        next_mode = sp_sw ? SCMS_MODE_SPEED : SCMS_MODE_PR;
      end
      `SCMS_CODE_PT_T: begin
        next_mode = tp_sw ? SCMS_MODE_TORQUE : SCMS_MODE_PT;
      end
      `SCMS_CODE_PR_T: begin
        next_mode = tp_sw ? SCMS_MODE_TORQUE : SCMS_MODE_PR;
      end
      `SCMS_CODE_S_T: begin
        // Torque while the switch is on, speed otherwise.
        next_mode = stq_sw ? SCMS_MODE_TORQUE
                           : SCMS_MODE_SPEED;
      end
      `SCMS_CODE_PT_PR: begin
        next_mode = pos_pick(tbl_sw);
      end
      `SCMS_CODE_PT_PR_S: begin
        next_mode = sp_sw ? SCMS_MODE_SPEED : pos_pick(tbl_sw);
      end
      `SCMS_CODE_PT_PR_T: begin
        next_mode = tp_sw ? SCMS_MODE_TORQUE : pos_pick(tbl_sw);
      end
      default: begin
        // Single torque mode is passed through so its zero variant
        // can act; every other single mode is outside this block.
        next_mode = i_single_torque_mode ? SCMS_MODE_TORQUE
                                         : SCMS_MODE_NONE;
      end
    endcase
  end

  logic is_pos_next;  // Requested mode is a position mode.
  logic is_pos_now;   // Current mode is a position mode.
  assign is_pos_next = next_mode inside {SCMS_MODE_PT, SCMS_MODE_PR};
  assign is_pos_now  = o_active_mode inside {SCMS_MODE_PT, SCMS_MODE_PR};

  // Registered mode and code validity.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_active_mode <= SCMS_MODE_NONE;
      o_code_valid  <= 1'b0;
    end else begin
      o_active_mode <= next_mode;
      o_code_valid  <= dual;
    end
  end

  // ============================================================
  // Position command sequencing.
  scms_pos_t pos_state;  // Hold or move.

  // Entering a position mode from elsewhere drops the command and
  // holds the motor; the trigger is only heard in a position mode.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pos_state         <= SCMS_POS_HOLD;
      o_position_preset <= `SCMS_RST_POS6;
    end else begin
      case (pos_state)
        SCMS_POS_HOLD: begin
          if (is_pos_next && is_pos_now && trig_rise) begin
            pos_state         <= SCMS_POS_MOVE;
            o_position_preset <= pos_sel;
          end
        end
        SCMS_POS_MOVE: begin
          if (!is_pos_next) begin
            pos_state <= SCMS_POS_HOLD;
          end else if (trig_rise) begin
            o_position_preset <= pos_sel;
          end
        end
        default: begin
          pos_state <= SCMS_POS_HOLD;
        end
      endcase
    end
  end

  // Hold is shown in position modes until a trigger has been taken.
  assign o_motor_hold = is_pos_now && (pos_state == SCMS_POS_HOLD);
  assign o_pos_move   = is_pos_now && (pos_state == SCMS_POS_MOVE);
  // Pulse-train mode follows pulses, table mode the presets.
  assign o_pos_from_pulses = (o_active_mode == SCMS_MODE_PT);

  // ============================================================
  // Command source selection.
  logic       tq_mode;  // Torque mode is active.
  logic       sp_mode;  // Speed mode is active.

  assign tq_mode = (o_active_mode == SCMS_MODE_TORQUE);
  assign sp_mode = (o_active_mode == SCMS_MODE_SPEED);

  // Speed source: zero means analog input, else a preset index.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_speed_source <= `SCMS_RST_SRC2;
    end else begin
      o_speed_source <= spd_sel;
    end
  end

  // Torque source follows the selects only once the servo is on;
  // before that the analog choice stands. A changed select takes
  // effect on the edge after it settles.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_torque_source <= `SCMS_RST_SRC2;
    end else if (srv_on) begin
      o_torque_source <= tcm_sel;
    end else begin
      o_torque_source <= `SCMS_RST_SRC2;
    end
  end

  // First torque choice is zero only in the zero-torque variant.
  assign o_torque_zero = tq_mode && tz_ok &&
                         (o_torque_source == 2'h0);

  // ============================================================
  // Limits. Sources mirror the command selects; a limit whose enable
  // is clear reports analog and off; a wrong mode only turns it off.
  logic spd_lim_en;  // Speed limit enable bit.
  logic tq_lim_en;   // Torque limit enable bit.

  assign spd_lim_en = i_limit_enable_parameter[`SCMS_LIM_SPEED_BIT];
  assign tq_lim_en  = i_limit_enable_parameter[`SCMS_LIM_TORQUE_BIT];

  // Speed limit only in torque mode.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_speed_limit_on     <= 1'b0;
      o_speed_limit_source <= `SCMS_RST_SRC2;
    end else begin
      o_speed_limit_on     <= (next_mode == SCMS_MODE_TORQUE)
                              && spd_lim_en;
      o_speed_limit_source <= spd_lim_en ? spd_sel
                              : `SCMS_RST_SRC2;
    end
  end

  // Torque limit only in position and speed modes.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_torque_limit_on     <= 1'b0;
      o_torque_limit_source <= `SCMS_RST_SRC2;
    end else begin
      o_torque_limit_on     <= (is_pos_next ||
                                next_mode == SCMS_MODE_SPEED)
                               && tq_lim_en;
      o_torque_limit_source <= tq_lim_en ? tcm_sel
                               : `SCMS_RST_SRC2;
    end
  end

  // ============================================================
  // Checks.
  speed_sw_follow_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_control_mode_parameter == `SCMS_CODE_PT_S && sp_sw)
    |=> o_active_mode == SCMS_MODE_SPEED)
    else $error("Speed mode not entered on switch.");
  torque_sw_follow_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_control_mode_parameter == `SCMS_CODE_S_T && $stable(
     i_control_mode_parameter) && stq_sw)
    |=> o_active_mode == SCMS_MODE_TORQUE)
    else $error("Torque mode not entered on switch.");
  hold_on_entry_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (!is_pos_now && is_pos_next) |=> o_motor_hold)
    else $error("Motor not held on position entry.");
  trig_latch_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (is_pos_now && is_pos_next && trig_rise)
    |=> o_pos_move && o_position_preset == $past(pos_sel))
    else $error("Trigger did not latch position.");
  trig_ignored_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (!is_pos_now && !is_pos_next) ##1 !is_pos_now
    |-> $stable(o_position_preset))
    else $error("Preset moved outside position mode.");
  spd_lim_mode_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    o_speed_limit_on |-> $past(next_mode) == SCMS_MODE_TORQUE)
    else $error("Speed limit outside torque mode.");
  tq_lim_en_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    !$past(tq_lim_en) |-> !o_torque_limit_on &&
    o_torque_limit_source == 2'h0)
    else $error("Torque limit acted while disabled.");
  servo_gate_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    !$past(srv_on) |-> o_torque_source == 2'h0)
    else $error("Torque select applied before servo on.");
  // Pulses may only drive the position from a code that offers them.
  pulse_src_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    o_pos_from_pulses |-> $past(dual) && !($past(i_control_mode_parameter)
    inside {`SCMS_CODE_PR_S, `SCMS_CODE_PR_T, `SCMS_CODE_S_T}))
    else $error("Pulse source outside pulse-train mode.");
  cov_pos_move_c: cover property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    o_motor_hold ##[1:50] o_pos_move);
  cov_st_swap_c: cover property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    sp_mode ##[1:50] tq_mode);
  cov_limits_c: cover property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    o_speed_limit_on ##[1:50] o_torque_limit_on);

endmodule

// *** rtl/scms_defines.svh ***
// Constants for the servo control mode selector.
// Assumes inclusion by bare name from rtl/ sources only.
`ifndef SCMS_DEFINES_SVH
`define SCMS_DEFINES_SVH

// ============================================================
// Control mode parameter codes.
`define SCMS_CODE_PT_S      8'h06
`define SCMS_CODE_PT_T      8'h07
`define SCMS_CODE_PR_S      8'h08
`define SCMS_CODE_PR_T      8'h09
`define SCMS_CODE_S_T       8'h0A
`define SCMS_CODE_PT_PR     8'h0D
`define SCMS_CODE_PT_PR_S   8'h0E
`define SCMS_CODE_PT_PR_T   8'h0F

// ============================================================
// Field layout of the limit enable parameter.
`define SCMS_LIM_SPEED_BIT  0
`define SCMS_LIM_TORQUE_BIT 1

// ============================================================
// Synchroniser vector layout (one bit per pin input).
`define SCMS_SYNC_W         17
`define SCMS_SY_SP          0
`define SCMS_SY_ST          1
`define SCMS_SY_TP          2
`define SCMS_SY_PP          3
`define SCMS_SY_TRIG        4
`define SCMS_SY_SRVON       5
`define SCMS_SY_SPD         6
`define SCMS_SY_TCM         8
`define SCMS_SY_POS         10
`define SCMS_SY_SPARE       16

// ============================================================
// Reset values.
`define SCMS_RST_SRC2       2'h0
`define SCMS_RST_POS6       6'h00

`endif

// *** rtl/scms_pkg.sv ***
// Types shared by the servo control mode selector.
// Assumes the defines header is compiled alongside.
package scms_pkg;

  // ============================================================
  // Active control mode reported to the drive core.
  typedef enum logic [2:0] {
    SCMS_MODE_NONE   = 3'b000,
    SCMS_MODE_PT     = 3'b001,
    SCMS_MODE_PR     = 3'b010,
    SCMS_MODE_SPEED  = 3'b011,
    SCMS_MODE_TORQUE = 3'b100
  } scms_mode_t;

  // Position command state: holding for a trigger, or moving.
  typedef enum logic [1:0] {
    SCMS_POS_HOLD = 2'b00,
    SCMS_POS_MOVE = 2'b01
  } scms_pos_t;

endpackage

// *** rtl/scms_sync.sv ***
// Three-stage synchroniser with agreement filter.
// Assumes asynchronous inputs and a single core clock.
`timescale 1ns/10ps
module scms_sync #(
  parameter int W = 1
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_stable
);

  // ============================================================
  // Stages; the first is read only by the second.
  logic [W-1:0] s1;  // First stage, metastability catcher.
  logic [W-1:0] s2;  // Second stage.
  logic [W-1:0] s3;  // Third stage.

  // Shift chain.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit takes its new value only once stages two and three agree.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_stable <= '0;
    end else begin
      for (int b = 0; b < W; b++) begin
        if (s2[b] == s3[b]) begin
          o_stable[b] <= s3[b];
        end
      end
    end
  end

endmodule

// *** verif/scms_ctrl_model.sv ***
// Partner model: the external motion controller that drives the pins.
// Assumes the bench calls its tasks and owns no pin itself.
`timescale 1ns/10ps
module scms_ctrl_model (
  input  wire logic       i_core_clk,
  output logic            o_servo_on,
  output logic            o_speed_pos_switch,
  output logic            o_speed_torque_switch,
  output logic            o_torque_pos_switch,
  output logic            o_pos_table_switch,
  output logic            o_position_trigger,
  output logic [1:0]      o_speed_select_inputs,
  output logic [1:0]      o_torque_select_inputs,
  output logic [5:0]      o_position_select_inputs
);
  // ============================================================
  // Pin drive
  // Everything starts low: servo off and every switch off.
  initial begin
    {o_servo_on, o_speed_pos_switch, o_speed_torque_switch,
     o_torque_pos_switch, o_pos_table_switch, o_position_trigger,
     o_speed_select_inputs, o_torque_select_inputs,
     o_position_select_inputs} = '0;
  end

  // Levels stand eight cycles, above the four the synchroniser needs.
  task automatic hold_level();
    repeat (8) @(posedge i_core_clk);
  endtask

  // Switch order in sw: servo, speed/pos, speed/torque, torque/pos, table.
  task automatic set_pins(input logic [4:0] sw, input logic [1:0] spd,
                          input logic [1:0] tcm, input logic [5:0] pos);
    @(negedge i_core_clk);
    {o_servo_on, o_speed_pos_switch, o_speed_torque_switch,
     o_torque_pos_switch, o_pos_table_switch} = sw;
    o_speed_select_inputs = spd;
    o_torque_select_inputs = tcm;
    o_position_select_inputs = pos;
    hold_level();
  endtask

  // One trigger pulse; the low phase keeps rises well apart.
  task automatic pulse_trigger();
    @(negedge i_core_clk);
    o_position_trigger = 1'b1;
    hold_level();
    @(negedge i_core_clk);
    o_position_trigger = 1'b0;
    hold_level();
  endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the control mode selector.
// Assumes the pin model above and a 40 MHz core clock.
`timescale 1ns/10ps
module testbench
  import scms_pkg::*;
;
  logic       i_core_clk;
  logic       i_arst_n;
  logic [7:0] code;
  logic [1:0] lim;
  logic       single;
  logic       zero;
  int         fails;
  int         samples_checked;
  logic       servo, sps, sts, tps, tbl, trig;
  logic [1:0] spd, tcm;
  logic [5:0] pos;
  logic [7:0] codes [9] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0D,
                            8'h0E, 8'h0F, 8'h05};
  scms_mode_t mode;
  logic       valid, hold, from_pulses, move, tzero, slon, tlon;
  logic [5:0] preset;
  logic [1:0] ssrc, tsrc, slsrc, tlsrc;

  scms_mode_selector uut (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_control_mode_parameter(code), .i_limit_enable_parameter(lim),
    .i_single_torque_mode(single), .i_zero_torque_variant(zero),
    .i_servo_on(servo), .i_speed_pos_switch(sps),
    .i_speed_torque_switch(sts), .i_torque_pos_switch(tps),
    .i_pos_table_switch(tbl), .i_position_trigger(trig),
    .i_speed_select_inputs(spd), .i_torque_select_inputs(tcm),
    .i_position_select_inputs(pos), .o_active_mode(mode),
    .o_code_valid(valid), .o_motor_hold(hold),
    .o_pos_from_pulses(from_pulses), .o_pos_move(move),
    .o_position_preset(preset), .o_speed_source(ssrc),
    .o_torque_source(tsrc), .o_torque_zero(tzero),
    .o_speed_limit_on(slon), .o_speed_limit_source(slsrc),
    .o_torque_limit_on(tlon), .o_torque_limit_source(tlsrc));

  scms_ctrl_model ctrl (
    .i_core_clk(i_core_clk), .o_servo_on(servo),
    .o_speed_pos_switch(sps), .o_speed_torque_switch(sts),
    .o_torque_pos_switch(tps), .o_pos_table_switch(tbl),
    .o_position_trigger(trig), .o_speed_select_inputs(spd),
    .o_torque_select_inputs(tcm), .o_position_select_inputs(pos));

  // ============================================================
  // Clock, verdict and watchdog
  // The clock toggles every 12.5 ns, a period of 25 ns.
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  // Single exit of the run, reached from the tests or the watchdog.
  task automatic stop_test();
    $display("Checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // The tests need under 2000 cycles; four times that means a hang.
  initial begin
    repeat (8000) @(posedge i_core_clk);
    fails++;
    stop_test();
  end

  // Four-state compare so an unknown output never passes.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ============================================================
  // Expectation functions
  // Mode chosen by code and filtered switches; not a copy of the logic.
  function automatic scms_mode_t exp_mode(input logic [7:0] c,
      input logic sp, input logic st, input logic tp, input logic tb);
    case (c)
      8'h06: return sp ? SCMS_MODE_SPEED : SCMS_MODE_PT;
      8'h07: return tp ? SCMS_MODE_TORQUE : SCMS_MODE_PT;
      8'h08: return sp ? SCMS_MODE_SPEED : SCMS_MODE_PR;
      8'h09: return tp ? SCMS_MODE_TORQUE : SCMS_MODE_PR;
      8'h0A: return st ? SCMS_MODE_TORQUE : SCMS_MODE_SPEED;
      8'h0D: return tb ? SCMS_MODE_PR : SCMS_MODE_PT;
      8'h0E: return sp ? SCMS_MODE_SPEED : (tb ? SCMS_MODE_PR : SCMS_MODE_PT);
      8'h0F: return tp ? SCMS_MODE_TORQUE : (tb ? SCMS_MODE_PR : SCMS_MODE_PT);
      default: return single ? SCMS_MODE_TORQUE : SCMS_MODE_NONE;
    endcase
  endfunction

  // Compares mode, validity, pulse source, limits and sources for one pin setting.
  task automatic check_cfg(input logic [4:0] sw, input logic [1:0] s,
                           input logic [1:0] t);
    scms_mode_t m;
    logic       pmode;
    m = exp_mode(code, sw[3], sw[2], sw[1], sw[0]);
    pmode = (m == SCMS_MODE_PT) || (m == SCMS_MODE_PR);
    check(8'(mode), 8'(m));
    check(8'(valid), 8'(code inside {[8'h06:8'h0A], [8'h0D:8'h0F]}));
    check(8'(from_pulses), 8'(m == SCMS_MODE_PT));
    check(8'(slon), 8'(m == SCMS_MODE_TORQUE && lim[0]));
    check(8'(tlon), 8'((pmode || m == SCMS_MODE_SPEED) && lim[1]));
    check(8'(ssrc), 8'(s));
    check(8'(tsrc), 8'(sw[4] ? t : 2'h0));
    check(8'(slsrc), 8'(lim[0] ? s : 2'h0));
    check(8'(tlsrc), 8'(lim[1] ? t : 2'h0));
  endtask

  // Sets pins, waits out the sync delay, then checks at a falling edge.
  task automatic step(input logic [4:0] sw, input logic [1:0] s,
                      input logic [1:0] t, input logic [5:0] p);
    ctrl.set_pins(sw, s, t, p);
    @(negedge i_core_clk);
    check_cfg(sw, s, t);
  endtask

  // Trigger pulse, then position command state against expectation.
  task automatic trig_chk(input logic h, input logic mv);
    ctrl.pulse_trigger();
    @(negedge i_core_clk);
    check({6'h00, hold, move}, {6'h00, h, mv});
  endtask

  // ============================================================
  // Main sequence
  initial begin
    {code, lim, single, zero, fails, samples_checked} = '0;
    i_arst_n = 1'b0;
    void'($urandom(32'hdec3334b));
    repeat (12) @(posedge i_core_clk);
    @(negedge i_core_clk);
    check(8'(mode), 8'h00);
    check({6'h00, hold, move}, 8'h00);
    i_arst_n = 1'b1;
    // Speed/position: speed, hold, trigger moves, back to speed.
    code = 8'h08;
    lim = 2'h3;
    step(5'b11000, 2'h2, 2'h1, 6'h2A);
    trig_chk(1'b0, 1'b0);
    step(5'b10000, 2'h2, 2'h1, 6'h2A);
    check({6'h00, hold, move}, 8'h02);
    trig_chk(1'b0, 1'b1);
    check(8'(preset), 8'h2A);
    step(5'b11000, 2'h3, 2'h1, 6'h15);
    check(8'(move), 8'h00);
    step(5'b10000, 2'h3, 2'h1, 6'h15);
    check({6'h00, hold, move}, 8'h02);
    // Torque/position over pulses: trigger ignored in torque.
    code = 8'h07;
    step(5'b10010, 2'h1, 2'h3, 6'h3F);
    trig_chk(1'b0, 1'b0);
    step(5'b10000, 2'h1, 2'h3, 6'h3F);
    check({6'h00, hold, move}, 8'h02);
    trig_chk(1'b0, 1'b1);
    check(8'(preset), 8'h3F);
    step(5'b10010, 2'h1, 2'h2, 6'h00);
    // Speed/torque with servo off, then on.
    code = 8'h0A;
    ctrl.set_pins(5'b00100, 2'h1, 2'h3, 6'h00);
    @(negedge i_core_clk);
    check(8'(tsrc), 8'h00);
    step(5'b10100, 2'h1, 2'h3, 6'h00);
    zero = 1'b1;
    step(5'b10100, 2'h1, 2'h0, 6'h00);
    check(8'(tzero), 8'h00);
    step(5'b10000, 2'h2, 2'h0, 6'h00);
    // Single torque, zero variant against plain torque.
    code = 8'h00;
    single = 1'b1;
    step(5'b10000, 2'h0, 2'h0, 6'h00);
    check(8'(tzero), 8'h01);
    zero = 1'b0;
    ctrl.set_pins(5'b10000, 2'h0, 2'h0, 6'h00);
    @(negedge i_core_clk);
    check(8'(tzero), 8'h00);
    single = 1'b0;
    // Random codes, switches, selects and limit enables.
    repeat (60) begin
      code = codes[$urandom % 9];
      lim = 2'($urandom);
      step({1'b1, 4'($urandom)}, 2'($urandom), 2'($urandom),
           6'($urandom));
    end
    stop_test();
  end
endmodule
